// >>> design/sdc_pkg.sv
package sdc_pkg;

  // register addresses on the serial configuration port
  localparam logic [6:0] ADDR_PD_DIV    = 7'h18;
  localparam logic [6:0] ADDR_BIAS_REL  = 7'h19;
  localparam logic [6:0] ADDR_PULSE_CNT = 7'h1a;
  localparam logic [6:0] ADDR_GDELAY    = 7'h1b;
  localparam logic [6:0] ADDR_MODE      = 7'h1c;
  localparam logic [6:0] ADDR_TOP_BIT   = 7'h70;

  // reset values
  localparam logic [7:0] RST_PD_DIV    = 8'h2f;
  localparam logic [7:0] RST_BIAS_REL  = 8'h81;
  localparam logic [7:0] RST_PULSE_CNT = 8'h02;
  localparam logic [7:0] RST_GDELAY    = 8'h00;
  localparam logic [1:0] RST_MODE      = 2'h0;
  localparam logic       RST_TOP_BIT   = 1'b0;

  // field positions
  localparam int PD_BIT      = 7;
  localparam int BIAS_BIT    = 7;
  localparam int TOP_BIT_POS = 7;
  localparam int DIV_TOP     = 6;
  localparam int DIV_MID_HI  = 4;
  localparam int DIV_MID_LO  = 2;
  localparam int DIV_LOW     = 0;

  // serial frame layout: rw bit, 7 address bits, 8 data bits
  localparam logic [4:0] FRAME_ADDR_END = 5'd8;
  localparam logic [4:0] FRAME_END      = 5'd16;

  localparam int NUM_LANES  = 8;
  localparam int RATIO_BITS = 13;

  typedef enum logic [1:0] {
    SDC_IDLE,
    SDC_ADDR,
    SDC_DATA
  } sdc_phase_type;

  typedef struct packed {
    logic [7:0] pd_div;
    logic [7:0] bias_rel;
    logic [7:0] pulse_cnt;
    logic [7:0] gdelay;
    logic [1:0] mode;
    logic       top_bit;
  } sdc_regs_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } sdc_pins_type;

  typedef struct packed {
    logic [NUM_LANES-1:0] level;
    logic [NUM_LANES-1:0] xbias;
  } sdc_lanes_type;

  typedef struct packed {
    sdc_pins_type          sync1;
    sdc_pins_type          sync2;
    logic                  sclk_prev;
    sdc_phase_type         phase;
    logic [4:0]            bitcnt;
    logic                  rd;
    logic [6:0]            addr;
    logic [7:0]            shin;
    logic [7:0]            shout;
    logic                  sdio_oe;
    sdc_regs_type          regs;
    logic [RATIO_BITS-1:0] cnt;
    logic                  tick;
    sdc_lanes_type         lanes;
  } sdc_state_type;

endpackage

// >>> design/sdc_sysref_divider.sv
// Summary of operation
// - power-down bit disables all sysref blocks
// - divider is four cascaded stages, own fields
// - total ratio is product of stages
// - middle stages divide by 2,4,8,16
// - low stage codes 01,10,11 give 3,4,5
// - divider field resets to 1280 setting
// - example setting gives divide by 384
// - bias select 0 gives static logic idle
// - bias select 1 gives cross-point idle
`timescale 1ns/100ps
module sdc_sysref_divider
  import sdc_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          resetn,
  input  wire logic                          spi_sclk,
  input  wire logic                          spi_cs_n,
  input  wire logic                          spi_sdio_in,
  output logic                               spi_sdio_out,
  output logic                               spi_sdio_oe,
  input  wire logic [sdc_pkg::NUM_LANES-1:0] output_idle_select_n,
  output logic [sdc_pkg::NUM_LANES-1:0]      sysref_output_lane,
  output logic [sdc_pkg::NUM_LANES-1:0]      sysref_lane_xbias,
  output logic                               sysref_tick,
  output logic [7:0]                         sysref_pulse_count,
  output logic [7:0]                         sysref_global_delay,
  output logic                               sysref_mode_bit_one,
  output logic                               sysref_mode_bit_zero,
  output logic                               top_bit_control
);
  import sdc_pkg::*;

  // stage decode; total is the product of four stages
  function automatic logic [RATIO_BITS-1:0] sdc_ratio(
    input logic [6:0] d
  );
    logic [4:0] low;
    logic [4:0] top_low;
    logic [3:0] sh;
    low = {3'h0, d[DIV_LOW +: 2]} + 5'h02;
    top_low = d[DIV_TOP] ? {low[2:0], 2'h0} : {low[3:0], 1'b0};
    sh = {2'h0, d[DIV_MID_HI +: 2]} + {2'h0, d[DIV_MID_LO +: 2]}
         + 4'h2;
    sdc_ratio = {8'h00, top_low} << sh;
  endfunction

  function automatic logic [7:0] sdc_read(
    input sdc_regs_type r,
    input logic [6:0]   a
  );
    case (a)
      ADDR_PD_DIV:    sdc_read = r.pd_div;
      ADDR_BIAS_REL:  sdc_read = r.bias_rel;
      ADDR_PULSE_CNT: sdc_read = r.pulse_cnt;
      ADDR_GDELAY:    sdc_read = r.gdelay;
      ADDR_MODE:      sdc_read = {6'h00, r.mode};
      ADDR_TOP_BIT:   sdc_read = {r.top_bit, 7'h00};
      default:        sdc_read = 8'h00;
    endcase
  endfunction

  sdc_state_type state;
  sdc_state_type next_state;

  logic                  pd;
  logic [RATIO_BITS-1:0] ratio;
  logic                  rise;
  logic                  fall;
  logic                  active;

  assign pd     = state.regs.pd_div[PD_BIT];
  assign ratio  = sdc_ratio(state.regs.pd_div[6:0]);
  assign rise   = state.sync2.sclk & ~state.sclk_prev;
  assign fall   = ~state.sync2.sclk & state.sclk_prev;
  assign active = ~state.sync2.cs_n;

  always_comb begin
    next_state = state;
    next_state.sync1 = '{sclk: spi_sclk, cs_n: spi_cs_n, sdio: spi_sdio_in};
    next_state.sync2 = state.sync1;
    next_state.sclk_prev = state.sync2.sclk;

    // serial configuration port
    if (!active) begin
      next_state.phase   = SDC_IDLE;
      next_state.bitcnt  = 5'h00;
      next_state.sdio_oe = 1'b0;
    end else begin
      case (state.phase)
        SDC_IDLE: begin
          next_state.phase  = SDC_ADDR;
          next_state.bitcnt = 5'h00;
        end
        SDC_ADDR: begin
          if (rise) begin
            next_state.shin   = {state.shin[6:0], state.sync2.sdio};
            next_state.bitcnt = state.bitcnt + 5'h01;
            if (state.bitcnt + 5'h01 == FRAME_ADDR_END) begin
              next_state.phase   = SDC_DATA;
              next_state.rd      = state.shin[6];
              next_state.addr    = {state.shin[5:0], state.sync2.sdio};
              next_state.shout   = sdc_read(state.regs,
                                    {state.shin[5:0], state.sync2.sdio});
              next_state.sdio_oe = state.shin[6];
            end
          end
        end
        SDC_DATA: begin
          if (fall && state.bitcnt > FRAME_ADDR_END) begin
            next_state.shout = {state.shout[6:0], 1'b0};
          end
          if (rise) begin
            next_state.shin   = {state.shin[6:0], state.sync2.sdio};
            next_state.bitcnt = state.bitcnt + 5'h01;
            if (state.bitcnt + 5'h01 == FRAME_END) begin
              next_state.phase = SDC_IDLE;
              if (!state.rd) begin
                case (state.addr)
                  ADDR_PD_DIV:
                    next_state.regs.pd_div = {state.shin[6:0],
                                              state.sync2.sdio};
                  ADDR_BIAS_REL:
                    next_state.regs.bias_rel = {state.shin[6:0],
                                                state.sync2.sdio};
                  ADDR_PULSE_CNT:
                    next_state.regs.pulse_cnt = {state.shin[6:0],
                                                 state.sync2.sdio};
                  ADDR_GDELAY:
                    next_state.regs.gdelay = {state.shin[6:0],
                                              state.sync2.sdio};
                  ADDR_MODE:
                    next_state.regs.mode = {state.shin[0],
                                            state.sync2.sdio};
                  ADDR_TOP_BIT:
                    next_state.regs.top_bit = state.shin[6];
                  default: ;
                endcase
              end
            end
          end
        end
        default: next_state.phase = SDC_IDLE;
      endcase
    end

    // sysref frequency divider
    if (pd) begin
      next_state.cnt  = '0;
      next_state.tick = 1'b0;
    end else if (state.cnt == '0) begin
      next_state.cnt  = ratio - 13'h0001;
      next_state.tick = 1'b1;
    end else begin
      next_state.cnt  = state.cnt - 13'h0001;
      next_state.tick = 1'b0;
    end

    // output lanes
    for (int i = 0; i < NUM_LANES; i++) begin
      if (pd) begin
        next_state.lanes.level[i] = 1'b0;
        next_state.lanes.xbias[i] = 1'b0;
      end else if (output_idle_select_n[i] || !next_state.tick) begin
        next_state.lanes.level[i] = 1'b0;
        next_state.lanes.xbias[i] = state.regs.bias_rel[BIAS_BIT];
      end else begin
        next_state.lanes.level[i] = 1'b1;
        next_state.lanes.xbias[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state                  <= '0;
      state.sync1            <= '{sclk: 1'b0, cs_n: 1'b1, sdio: 1'b0};
      state.sync2            <= '{sclk: 1'b0, cs_n: 1'b1, sdio: 1'b0};
      state.phase            <= SDC_IDLE;
      state.regs.pd_div      <= RST_PD_DIV;
      state.regs.bias_rel    <= RST_BIAS_REL;
      state.regs.pulse_cnt   <= RST_PULSE_CNT;
      state.regs.gdelay      <= RST_GDELAY;
      state.regs.mode        <= RST_MODE;
      state.regs.top_bit     <= RST_TOP_BIT;
    end else begin
      state <= next_state;
    end
  end

  assign spi_sdio_out         = state.shout[7];
  assign spi_sdio_oe          = state.sdio_oe;
  assign sysref_output_lane   = state.lanes.level;
  assign sysref_lane_xbias    = state.lanes.xbias;
  assign sysref_tick          = state.tick;
  assign sysref_pulse_count   = state.regs.pulse_cnt;
  assign sysref_global_delay  = state.regs.gdelay;
  assign sysref_mode_bit_one  = state.regs.mode[1];
  assign sysref_mode_bit_zero = state.regs.mode[0];
  assign top_bit_control      = state.regs.top_bit;

endmodule // sdc_sysref_divider

// >>> test/sdc_converter_model.sv
`timescale 1ns/100ps
module sdc_converter_model (
  input wire logic [7:0] lane,
  input wire logic       ref_clk,
  output logic [7:0]     seen
);
  // remembers which lanes carried the latest alignment pulse
  always_ff @(posedge ref_clk) begin
    if (|lane) seen <= lane;
  end
endmodule // sdc_converter_model

// >>> test/sdc_sysref_divider_asserts.sv
`timescale 1ns/100ps
module sdc_sysref_divider_asserts
  import sdc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       spi_cs_n,
  input wire logic       spi_sdio_oe,
  input wire logic [7:0] output_idle_select_n,
  input wire logic [7:0] sysref_output_lane,
  input wire logic [7:0] sysref_lane_xbias,
  input wire logic       sysref_tick,
  input wire logic [7:0] sysref_pulse_count,
  input wire logic       top_bit_control
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  lane_tick_a: assert property (
    |sysref_output_lane |-> sysref_tick) else $error("pulse without tick");
  lane_xbias_a: assert property (
    (sysref_output_lane & sysref_lane_xbias) == 8'h00)
    else $error("pulse and bias together");
  idle_hold_a: assert property (
    (output_idle_select_n & $past(output_idle_select_n)
     & sysref_output_lane) == 8'h00) else $error("idle lane pulsed");
  tick_gap_a: assert property (
    sysref_tick |=> !sysref_tick [*8]) else $error("ticks too close");
  reset_out_a: assert property (
    $rose(resetn) |-> sysref_pulse_count == 8'h02 && !top_bit_control
    && !sysref_tick && sysref_output_lane == 8'h00)
    else $error("bad values at reset release");
  oe_start_a: assert property (
    $rose(spi_sdio_oe) |-> !spi_cs_n) else $error("drive outside frame");
  oe_stop_a: assert property (
    $rose(spi_cs_n) |-> ##[1:5] !spi_sdio_oe) else $error("drive held");
  regs_idle_a: assert property (
    spi_cs_n [*6] |=> $stable(sysref_pulse_count))
    else $error("register changed outside frame");
  tick_c: cover property (sysref_tick);
  read_c: cover property ($rose(spi_sdio_oe));
  lane_c: cover property (|sysref_output_lane);
endmodule // sdc_sysref_divider_asserts
bind sdc_sysref_divider sdc_sysref_divider_asserts chk_u (.*);

// >>> test/sysref_divider_control_tb_top.sv
`timescale 1ns/100ps
module sysref_divider_control_tb_top;
  import sdc_pkg::*;
  logic ref_clk = 0, resetn = 0, sclk = 0, cs_n = 1, sdo = 0;
  logic [7:0] idle_n = 0, rd, seen, lanes, xb, pc;
  logic out, oe, tick, topb;
  wire sdio = oe ? out : sdo;
  int errors = 0, checks = 0, n;
  logic [6:0] sa [5] = '{7'h00, 7'h7f, 7'h4a, 7'h26, 7'h1d};
  int sr [5] = '{16, 5120, 256, 256, 384};
  logic [6:0] ra [7] = '{7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h70, 7'h20};
  logic [7:0] re [7] = '{8'h2f, 8'h81, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv [5] = '{8'h5a, 8'ha5, 8'hff, 8'hff, 8'hff};
  logic [7:0] we [5] = '{8'h5a, 8'ha5, 8'h03, 8'h80, 8'h00};
  always #2.5 ref_clk = ~ref_clk;
  sdc_sysref_divider dut_u (.ref_clk(ref_clk), .resetn(resetn),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdio_in(sdio),
    .spi_sdio_out(out), .spi_sdio_oe(oe), .output_idle_select_n(idle_n),
    .sysref_output_lane(lanes), .sysref_lane_xbias(xb),
    .sysref_tick(tick), .sysref_pulse_count(pc),
    .sysref_global_delay(), .sysref_mode_bit_one(),
    .sysref_mode_bit_zero(), .top_bit_control(topb));
  sdc_converter_model model_u (.lane(lanes), .ref_clk(ref_clk),
    .seen(seen));
  task cmp8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cmpn(input int g, input int e);
    checks++;
    if (g != e) begin
      errors++;
      $display("Error %0t: count %0d expected %0d", $time, g, e);
    end
  endtask
  task xfer(input logic r, input logic [6:0] a, input logic [7:0] w);
    logic [15:0] f;
    f = {r, a, w};
    cs_n <= 0;
    for (int i = 0; i < 16; i++) begin
      sdo <= f[15-i];
      repeat (6) @(posedge ref_clk);
      if (i > 7) rd[15-i] = sdio;
      sclk <= 1;
      repeat (6) @(posedge ref_clk);
      sclk <= 0;
    end
    repeat (6) @(posedge ref_clk);
    cs_n <= 1;
    repeat (8) @(posedge ref_clk);
  endtask
  task period;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (tick !== 1 && n < 6000);
    n = 0;
    do begin @(negedge ref_clk); n++; end while (tick !== 1 && n < 6000);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge ref_clk);
    errors++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1;
    for (int i = 0; i < 7; i++) begin
      xfer(1, ra[i], 8'h00);
      cmp8(rd, re[i]);
    end
    period;
    period;
    cmpn(n, 1280);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      xfer(0, 7'h18, {1'b0, sa[i]});
      period;
      period;
      cmpn(n, sr[i]);
    end
    $display("test stages done");
    xfer(0, 7'h18, 8'h9d);
    n = 0;
    repeat (2000) @(negedge ref_clk) if (tick !== 0 || lanes !== 0) n++;
    cmpn(n, 0);
    xfer(0, 7'h18, 8'h1d);
    period;
    period;
    cmpn(n, 384);
    $display("test powerdown done");
    @(posedge ref_clk) idle_n <= 8'h0f;
    period;
    period;
    cmp8(seen, 8'hf0);
    @(negedge ref_clk) cmp8(xb, 8'hff);
    xfer(0, 7'h19, 8'h01);
    @(negedge ref_clk) cmp8(xb, 8'h00);
    $display("test lanes done");
    for (int i = 0; i < 5; i++) begin
      xfer(0, ra[i+2] == 7'h1b ? 7'h1b : ra[i+2], wv[i]);
      xfer(1, ra[i+2], 8'h00);
      cmp8(rd, we[i]);
    end
    cmp8({7'h00, topb}, 8'h01);
    cmp8(pc, 8'h5a);
    $display("test registers done");
    final_report;
  end
endmodule // sysref_divider_control_tb_top
